// ---- hw/irc_defs.svh ----
// Register offsets, field positions and reset values for the input reference config bank
`ifndef IRC_DEFS_SVH
`define IRC_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define IRC_IDX_PRIO 8'h1e
`define IRC_IDX_IN1 8'h1f
`define IRC_IDX_IN2 8'h21
`define IRC_IDX_IN3 8'h22
`define IRC_IDX_CTRL 8'h30

// Field positions
`define IRC_PRIO13_HI 3
`define IRC_PRIO13_LO 0
`define IRC_BKT_HI 5
`define IRC_BKT_LO 4
`define IRC_DIVN_BIT 7
`define IRC_LOCK8K_BIT 6
`define IRC_VIEW_BIT 0

// Writable masks: input 1 and 2 keep only the profile field
`define IRC_IN12_MASK 8'h30
`define IRC_IN3_MASK 8'hff

// Reset values
`define IRC_PRIO_RST_MAIN 8'hfe
`define IRC_PRIO_RST_AUX 8'h00
`define IRC_CFG_RST 8'h00
`define IRC_PRIO_OFF 4'h0

`endif

// ---- hw/irc_pkg.sv ----
// Types shared by the input reference configuration bank
package irc_pkg;
    typedef logic [7:0] irc_byte_t; // One 8-bit register
    typedef enum logic [1:0] {
        IRC_IDLE,
        IRC_ACCESS
    } irc_phase_e; // APB slave phase
endpackage

// ---- hw/irc_regs.sv ----
// APB register bank configuring input reference clocks I1, I2, I3 and I13 priority
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "irc_defs.svh"

// How it works
// - I13 priority nibble; zero disables, low wins.
// - Priority register RW, reset per path view.
// - Input 1 config resets zero, fixed 8k.
// - Input 2 config resets zero, fixed 8k.
// - Input 3 bit7 picks direct or pre-divided.
// - Divided clock feeds both DPLL and monitor.
// - Bits 5:4 pick leaky bucket profile.
module irc_regs
    import irc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i3_raw_clk,
    input wire logic i3_prog_div_clk,
    input wire logic i3_preset_8k_clk,
    output logic i3_dpll_clk,
    output logic i3_freq_mon_clk,
    output logic [3:0] i13_priority,
    output logic i13_auto_enable,
    output logic [1:0] input1_monitor_profile_sel,
    output logic [1:0] input2_monitor_profile_sel,
    output logic [1:0] monitor_profile_sel,
    output logic eight_khz_lock_sel,
    output logic i3_prediv_sel,
    output logic path_view_sel
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    irc_byte_t prio; // I13/I14 priority
    irc_byte_t in1_cfg; // Input 1 config
    irc_byte_t in2_cfg; // Input 2 config
    irc_byte_t in3_cfg; // Input 3 config
    logic view; // Path view select
    logic view_seen; // Captured view used by priority reset
    irc_byte_t next_prio;
    irc_byte_t next_in1_cfg;
    irc_byte_t next_in2_cfg;
    irc_byte_t next_in3_cfg;
    logic next_view;
    logic next_view_seen;
    logic [31:0] next_prdata;
    logic next_pslverr;
    irc_phase_e phase;
    irc_phase_e next_phase;

    // Byte address of a register index
    function automatic logic [31:0] reg_addr(input logic [7:0] idx);
        reg_addr = {22'h000000, idx, 2'b00};
    endfunction

    // Merge byte lane 0 of a write under a writable mask
    // Lanes 1-3 carry nothing: every register fits in one byte
    function automatic irc_byte_t lane0(input irc_byte_t old, input irc_byte_t wr,
                                         input irc_byte_t msk, input logic en);
        lane0 = en ? ((wr & msk) | (old & ~msk)) : old;
    endfunction

    logic wr_acc; // Write completes this edge
    logic rd_acc; // Read completes this edge
    logic hit; // Address decodes to a register

    // One wait-free access phase: pready is high throughout
    // Access only counts after a setup cycle; a stray penable without setup is ignored
    // This costs a two-bit phase register but keeps a glitchy master from committing a write
    assign wr_acc = (phase == IRC_ACCESS) & psel & penable & pwrite;
    assign rd_acc = (phase == IRC_ACCESS) & psel & penable & ~pwrite;
    assign pready = 1'b1;
    // Full 32-bit compare: aliases of a register are treated as unmapped
    assign hit = (paddr == reg_addr(`IRC_IDX_PRIO)) || (paddr == reg_addr(`IRC_IDX_IN1)) ||
                 (paddr == reg_addr(`IRC_IDX_IN2)) || (paddr == reg_addr(`IRC_IDX_IN3)) ||
                 (paddr == reg_addr(`IRC_IDX_CTRL));

    ////////////////////////////////////////////////////////////////////////////
    // Next-state for registers and bus answer
    always_comb begin
        next_prio = prio;
        next_in1_cfg = in1_cfg;
        next_in2_cfg = in2_cfg;
        next_in3_cfg = in3_cfg;
        next_view = view;
        next_view_seen = view_seen;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_phase = (psel & ~penable) ? IRC_ACCESS : IRC_IDLE;
        // Priority reloads when the view changes, so each path starts from its default
        // Hazard: a priority write landing in the reload cycle wins over the default
        if (view != view_seen) begin
            next_prio = view ? `IRC_PRIO_RST_AUX : `IRC_PRIO_RST_MAIN;
            next_view_seen = view;
        end
        if (psel & ~penable) begin
            // Setup: prepare read data so it is registered at the access edge
            // prdata then holds between transfers, so a late sample sees the last answer
            unique case (paddr)
                reg_addr(`IRC_IDX_PRIO): next_prdata = {24'h000000, prio};
                reg_addr(`IRC_IDX_IN1): next_prdata = {24'h000000, in1_cfg};
                reg_addr(`IRC_IDX_IN2): next_prdata = {24'h000000, in2_cfg};
                reg_addr(`IRC_IDX_IN3): next_prdata = {24'h000000, in3_cfg};
                reg_addr(`IRC_IDX_CTRL): next_prdata = {31'h00000000, view};
                default: next_prdata = 32'h00000000;
            endcase
            next_pslverr = ~hit;
        end else if (psel & penable) begin
            next_pslverr = pslverr;
        end
        if (wr_acc) begin
            // Unmapped writes are dropped and flagged by pslverr
            unique case (paddr)
                reg_addr(`IRC_IDX_PRIO): next_prio = lane0(prio, pwdata[7:0], 8'hff, pstrb[0]);
                // Fixed 8k inputs: frequency and top bits never store a one
                reg_addr(`IRC_IDX_IN1): next_in1_cfg = lane0(in1_cfg, pwdata[7:0], `IRC_IN12_MASK, pstrb[0]);
                reg_addr(`IRC_IDX_IN2): next_in2_cfg = lane0(in2_cfg, pwdata[7:0], `IRC_IN12_MASK, pstrb[0]);
                reg_addr(`IRC_IDX_IN3): next_in3_cfg = lane0(in3_cfg, pwdata[7:0], `IRC_IN3_MASK, pstrb[0]);
                reg_addr(`IRC_IDX_CTRL): next_view = pstrb[0] ? pwdata[`IRC_VIEW_BIT] : view;
                default: next_view = view;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register update
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prio <= `IRC_PRIO_RST_MAIN;
            in1_cfg <= `IRC_CFG_RST;
            in2_cfg <= `IRC_CFG_RST;
            in3_cfg <= `IRC_CFG_RST;
            view <= 1'b0;
            view_seen <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            phase <= IRC_IDLE;
        end else begin
            prio <= next_prio;
            in1_cfg <= next_in1_cfg;
            in2_cfg <= next_in2_cfg;
            in3_cfg <= next_in3_cfg;
            view <= next_view;
            view_seen <= next_view_seen;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            phase <= next_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded controls
    // Zero takes I13 out of automatic selection; smaller nonzero wins
    assign i13_priority = prio[`IRC_PRIO13_HI:`IRC_PRIO13_LO];
    assign i13_auto_enable = (i13_priority != `IRC_PRIO_OFF);
    assign input1_monitor_profile_sel = in1_cfg[`IRC_BKT_HI:`IRC_BKT_LO];
    assign input2_monitor_profile_sel = in2_cfg[`IRC_BKT_HI:`IRC_BKT_LO];
    assign monitor_profile_sel = in3_cfg[`IRC_BKT_HI:`IRC_BKT_LO];
    assign i3_prediv_sel = in3_cfg[`IRC_DIVN_BIT];
    assign eight_khz_lock_sel = in3_cfg[`IRC_LOCK8K_BIT];
    // Zero selects the main path view, one the aux view
    assign path_view_sel = view;

    // Clock steering is a plain mux; a glitch on change is tolerated by the DPLL
    // Programmable divider routing wins over the preset 8k divider
    always_comb begin
        if (i3_prediv_sel) begin
            i3_dpll_clk = i3_prog_div_clk;
        end else if (eight_khz_lock_sel) begin
            i3_dpll_clk = i3_preset_8k_clk;
        end else begin
            i3_dpll_clk = i3_raw_clk;
        end
        // Monitor never sees the raw clock while pre-dividing
        i3_freq_mon_clk = i3_prediv_sel ? i3_prog_div_clk : i3_raw_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    // Each label line carries the tag of the rule it guards
    AST_PRIO_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        (i13_priority == 4'h0) |-> !i13_auto_enable) else $error("I13 enabled with zero priority");
    AST_PRIO_WR: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_acc && paddr == reg_addr(`IRC_IDX_PRIO) && pstrb[0] && view == view_seen) |=>
        prio == $past(pwdata[7:0])) else $error("Priority write not stored");
    AST_VIEW_RST: assert property (@(posedge clk) disable iff (!rst_b)
        (view != view_seen && !wr_acc) |=> prio == (view_seen ? `IRC_PRIO_RST_AUX : `IRC_PRIO_RST_MAIN))
        else $error("Priority view reload wrong");
    AST_IN1_FIX: assert property (@(posedge clk) disable iff (!rst_b)
        (in1_cfg & 8'hcf) == 8'h00) else $error("Input 1 fixed bits set");
    AST_IN2_FIX: assert property (@(posedge clk) disable iff (!rst_b)
        (in2_cfg & 8'hcf) == 8'h00) else $error("Input 2 fixed bits set");
    AST_DIV_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
        !in3_cfg[`IRC_DIVN_BIT] && !in3_cfg[`IRC_LOCK8K_BIT] |-> i3_dpll_clk == i3_raw_clk)
        else $error("Raw routing wrong");
    AST_DIV_BOTH: assert property (@(posedge clk) disable iff (!rst_b)
        in3_cfg[`IRC_DIVN_BIT] |-> (i3_dpll_clk == i3_prog_div_clk && i3_freq_mon_clk == i3_prog_div_clk))
        else $error("Divided clock not on both");
    AST_LOCK8K: assert property (@(posedge clk) disable iff (!rst_b)
        (!in3_cfg[`IRC_DIVN_BIT] && in3_cfg[`IRC_LOCK8K_BIT]) |-> i3_dpll_clk == i3_preset_8k_clk)
        else $error("Preset 8k routing wrong");
    AST_BUCKET: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_acc && paddr == reg_addr(`IRC_IDX_IN3) && pstrb[0]) |=>
        monitor_profile_sel == $past(pwdata[`IRC_BKT_HI:`IRC_BKT_LO])) else $error("Bucket select not updated");
    // Unmapped setup must answer with an error in the access phase
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_b)
        (psel && !penable && !hit) |=> pslverr) else $error("Unmapped access not flagged");

    // Covers mark the main scenarios the bench must reach
    COV_WR_IN3: cover property (@(posedge clk) disable iff (!rst_b) wr_acc && paddr == reg_addr(`IRC_IDX_IN3));
    COV_RD_PRIO: cover property (@(posedge clk) disable iff (!rst_b) rd_acc && paddr == reg_addr(`IRC_IDX_PRIO));
    COV_VIEW: cover property (@(posedge clk) disable iff (!rst_b) view && view_seen);
    COV_ERR: cover property (@(posedge clk) disable iff (!rst_b) pslverr && psel && penable);
    COV_LOCK8K: cover property (@(posedge clk) disable iff (!rst_b) eight_khz_lock_sel && !i3_prediv_sel);

endmodule // irc_regs

// ---- testbench/tb.sv ----
// Self-checking testbench for the input reference config register bank
`timescale 1ns/100ps
module tb;
import irc_pkg::*;
localparam logic [31:0] A_PRIO = 32'h78, A_IN1 = 32'h7c, A_IN2 = 32'h84, A_IN3 = 32'h88, A_CTRL = 32'hc0;
logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err; // Bus controls
logic [31:0] paddr, pwdata, prdata, rd; // Bus data
logic [3:0] pstrb, prio;
logic raw, pdiv, p8k, dpll, fmon, auto_en, lock8k, prediv, view; // Input 3 clocks and selects
logic [1:0] prof1, prof2, prof3; // Monitor profile selects
int n_mismatch, n_checks, cyc;
irc_regs i_irc_regs (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i3_raw_clk(raw), .i3_prog_div_clk(pdiv), .i3_preset_8k_clk(p8k), .i3_dpll_clk(dpll),
    .i3_freq_mon_clk(fmon), .i13_priority(prio), .i13_auto_enable(auto_en),
    .input1_monitor_profile_sel(prof1), .input2_monitor_profile_sel(prof2),
    .monitor_profile_sel(prof3), .eight_khz_lock_sel(lock8k), .i3_prediv_sel(prediv),
    .path_view_sel(view));
////////////////////////////////////////////////////////////
// Clock, 4 ns period
initial begin
    clk = 0;
    forever #2 clk = ~clk;
end
// Hang guard, far above the roughly 140 cycles the run needs
always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
        n_mismatch++;
        complete_run;
    end
end
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
// One APB transfer; waits an edge first so release and next setup never share a step
task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready is tied high, so this wait ends after one edge
    do begin
        @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Let flops written at this edge settle before callers look at outputs
    #1;
endtask
////////////////////////////////////////////////////////////
task t_reset;
    apb(0, A_PRIO, 0); chk(rd, 32'hfe);
    chk(prio, 4'he); chk(auto_en, 1'b1);
    apb(0, A_IN1, 0); chk(rd, 32'h0);
    apb(0, A_IN2, 0); chk(rd, 32'h0);
    apb(0, A_IN3, 0); chk(rd, 32'h0); chk(err, 1'b0);
endtask
// Zero, top and bottom priority codes, then a masked-off lane
task t_prio;
    logic [3:0] c[3];
    c = '{4'h0, 4'h1, 4'hf};
    for (int i = 0; i < 3; i++) begin
        apb(1, A_PRIO, {24'h0, 4'ha, c[i]});
        apb(0, A_PRIO, 0); chk(rd, {24'h0, 4'ha, c[i]});
        chk(prio, c[i]); chk(auto_en, c[i] != 4'h0);
    end
    pstrb <= 4'h0;
    apb(1, A_PRIO, 32'h77);
    pstrb <= 4'hf;
    apb(0, A_PRIO, 0); chk(rd, 32'haf);
endtask
// Fixed 8 kHz inputs keep only the profile field
task t_in12;
    apb(1, A_IN1, 32'hff); apb(0, A_IN1, 0); chk(rd, 32'h30);
    chk(prof1, 2'h3);
    apb(1, A_IN2, 32'hdf); apb(0, A_IN2, 0); chk(rd, 32'h10);
    chk(prof2, 2'h1);
endtask
// Every profile code, then every routing combination against one-hot sources
task t_in3;
    logic [7:0] v[4];
    logic [2:0] pat;
    v = '{8'h00, 8'h40, 8'h80, 8'hc0};
    for (int b = 0; b < 4; b++) begin
        apb(1, A_IN3, {24'h0, 2'b00, b[1:0], 4'h5});
        apb(0, A_IN3, 0); chk(rd, {24'h0, 2'b00, b[1:0], 4'h5});
        chk(prof3, b[1:0]);
    end
    for (int m = 0; m < 4; m++) begin
        apb(1, A_IN3, {24'h0, v[m]});
        chk(lock8k, v[m][6]); chk(prediv, v[m][7]);
        for (int k = 0; k < 3; k++) begin
            pat = 3'b100 >> k;
            @(posedge clk);
            {raw, pdiv, p8k} <= pat;
            #1;
            chk(dpll, v[m][7] ? pat[1] : (v[m][6] ? pat[0] : pat[2]));
            chk(fmon, v[m][7] ? pat[1] : pat[2]);
        end
    end
endtask
// Path view switch reloads the priority defaults
task t_view;
    apb(1, A_CTRL, 32'h1); chk(view, 1'b1);
    apb(0, A_PRIO, 0); chk(rd, 32'h00);
    apb(1, A_CTRL, 32'h0); chk(view, 1'b0);
    apb(0, A_PRIO, 0); chk(rd, 32'hfe);
endtask
task t_unmapped;
    apb(1, 32'h40, 32'hff); chk(err, 1'b1);
    apb(0, 32'h40, 0); chk(rd, 32'h0); chk(err, 1'b1);
    apb(0, A_IN2, 0); chk(rd, 32'h10); chk(err, 1'b0);
endtask
////////////////////////////////////////////////////////////
initial begin
    rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hf;
    raw = 0; pdiv = 0; p8k = 0; n_mismatch = 0; n_checks = 0; cyc = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_prio;
    t_in12;
    t_in3;
    t_view;
    t_unmapped;
    complete_run;
end
endmodule // tb
